// ---- logic/monitor_pkg.sv ----
package monitor_pkg;
    // host address map
    localparam logic [15:0] MON_BASE       = 16'h7000;
    localparam logic [15:0] MON_LAST       = 16'h7044;
    localparam logic [15:0] HOST_SET_ADDR  = 16'h1000;
    // word index inside the monitor group
    localparam logic [6:0] IX_RUN_FREQ  = 7'h00;
    localparam logic [6:0] IX_SET_FREQ  = 7'h01;
    localparam logic [6:0] IX_BUS_VOLT  = 7'h02;
    localparam logic [6:0] IX_OUT_VOLT  = 7'h03;
    localparam logic [6:0] IX_OUT_CUR   = 7'h04;
    localparam logic [6:0] IX_OUT_POW   = 7'h05;
    localparam logic [6:0] IX_OUT_TRQ   = 7'h06;
    localparam logic [6:0] IX_IN_LVL    = 7'h07;
    localparam logic [6:0] IX_OUT_LVL   = 7'h08;
    localparam logic [6:0] IX_LOAD_SPD  = 7'h0e;
    localparam logic [6:0] IX_LOOP_SET  = 7'h0f;
    localparam logic [6:0] IX_LOOP_FB   = 7'h10;
    localparam logic [6:0] IX_ACT_FREQ  = 7'h13;
    localparam logic [6:0] IX_REMAIN    = 7'h14;
    localparam logic [6:0] IX_AN1_RAW   = 7'h15;
    localparam logic [6:0] IX_AN2_RAW   = 7'h16;
    localparam logic [6:0] IX_LIN_SPD   = 7'h18;
    localparam logic [6:0] IX_HOST_SET  = 7'h1b;
    localparam logic [6:0] IX_ENC_FREQ  = 7'h1c;
    localparam logic [6:0] IX_MAIN_FREQ = 7'h1d;
    localparam logic [6:0] IX_AUX_FREQ  = 7'h1e;
    localparam logic [6:0] IX_TGT_TRQ   = 7'h22;
    localparam logic [6:0] IX_RESOLVER  = 7'h23;
    localparam logic [6:0] IX_PF_ANGLE  = 7'h24;
    // field positions
    localparam int IN_SW_LSB   = 0;
    localparam int IN_VIRT_LSB = 10;
    localparam int OUT_RELAY   = 1;
    localparam int OUT_DOUT    = 3;
    localparam int OUT_VIRT_LSB = 5;
    // resolution select codes
    localparam logic [1:0] RES_TENTHS     = 2'h1;
    localparam logic [1:0] RES_HUNDREDTHS = 2'h2;
    // limits and scales
    localparam logic signed [15:0] FREQ_LIMIT   = 16'sh7530;
    localparam logic signed [15:0] TORQUE_LIMIT = 16'sh07d0;
    localparam logic [15:0] OUT_LVL_LIMIT = 16'h03ff;
    localparam logic [15:0] RESOLVER_MAX  = 16'h0fff;
    localparam logic [15:0] REMAIN_MAX    = 16'hfde8;
    localparam logic [15:0] ANALOG_MAX    = 16'h0421;
    localparam logic [15:0] PCT_FULL      = 16'h2710;
    localparam logic [15:0] WORD_MAX      = 16'hffff;
    localparam logic [15:0] RESET_WORD    = 16'h0000;

    typedef struct packed {
        logic signed [19:0] run_freq;
        logic signed [19:0] set_freq;
        logic signed [19:0] act_freq;
        logic signed [19:0] enc_freq;
        logic signed [19:0] main_freq;
        logic signed [19:0] aux_freq;
        logic [15:0]        bus_volt;
        logic [15:0]        out_volt;
        logic [19:0]        out_cur;
        logic [15:0]        out_power;
        logic signed [15:0] out_torque;
        logic signed [15:0] torque_limit;
        logic [4:0]         switch_input;
        logic [4:0]         virtual_input;
        logic               relay_out;
        logic               switch_output;
        logic [4:0]         virtual_output;
        logic [15:0]        load_speed;
        logic [15:0]        loop_set_pct;
        logic [15:0]        loop_fb_pct;
        logic [15:0]        remain_time;
        logic [15:0]        an1_raw;
        logic [15:0]        an2_raw;
        logic [31:0]        pulses_per_min;
        logic [15:0]        resolver;
        logic [15:0]        pf_angle;
    } drive_sample_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } host_rsp_t;
endpackage : monitor_pkg

// ---- logic/drive_monitor_status_bank.sv ----
`timescale 1ns/1ps
// Overview of operation
// [R1] host reads monitor words at addresses 0x7000 through 0x7044
// [R2] input word: bits 0-4 switch inputs, 5-9 zero, 10+ virtual inputs
// [R3] output word within 0-1023: relay bit 1, output bit 3, virtual 5-9
// [R4] signed frequency: one decimal when select is 1, two when 2
// [R5] running and set frequency shown as unsigned magnitudes
// [R6] current two decimals on small units, one decimal on large units
// [R7] last host value written to 0x1000 shown as signed percentage
// [R8] resolver angle reported unsigned from 0 to 4095
// [R9] output torque clamped to plus or minus 200.0 percent
// [R10] target torque is torque upper limit, clamped to 200.0 percent
// [R11] linear speed is pulses per minute over pulses per metre, saturated
// [R12] remaining run time in tenths of minute, only while timing enabled
// [R13] both analog raw samples reported 0.00 to 10.57 V uncorrected
// [R14] loop setpoint and feedback are percentage times scale, saturated
// [R15] reads have no side effects; writes into monitor span are ignored
module drive_monitor_status_bank
    import monitor_pkg::*;
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    // host access
    input  wire monitor_pkg::host_req_t     host_req,
    output monitor_pkg::host_rsp_t          host_rsp,
    // measured values from the drive core
    input  wire monitor_pkg::drive_sample_t drive_in,
    // settings
    input  wire logic [1:0]                 frequency_resolution_select,
    input  wire logic [15:0]                pulses_per_metre_setting,
    input  wire logic [15:0]                loop_scale_setting,
    input  wire logic                       large_unit,
    input  wire logic                       timed_run_enable
);
    import monitor_pkg::*;

    // one decimal drops a digit; out-of-range codes fall back to two
    function automatic logic signed [15:0] scale_freq(
        input logic signed [19:0] raw,
        input logic [1:0]         res
    );
        logic signed [19:0] v;
        v = (res == RES_TENTHS) ? raw / 20'sd10 : raw;
        if (v > 20'(FREQ_LIMIT))
            scale_freq = FREQ_LIMIT;
        else if (v < -20'(FREQ_LIMIT))
            scale_freq = -FREQ_LIMIT;
        else
            scale_freq = v[15:0];
    endfunction : scale_freq

    function automatic logic signed [15:0] clamp_torque(
        input logic signed [15:0] raw
    );
        if (raw > TORQUE_LIMIT)
            clamp_torque = TORQUE_LIMIT;
        else if (raw < -TORQUE_LIMIT)
            clamp_torque = -TORQUE_LIMIT;
        else
            clamp_torque = raw;
    endfunction : clamp_torque

    function automatic logic [15:0] clamp_u(
        input logic [15:0] raw,
        input logic [15:0] lim
    );
        clamp_u = (raw > lim) ? lim : raw;
    endfunction : clamp_u

    function automatic logic [15:0] loop_value(
        input logic [15:0] pct,
        input logic [15:0] scale
    );
        logic [31:0] q;
        q = (32'(pct) * 32'(scale)) / 32'(PCT_FULL);
        loop_value = (q > 32'(WORD_MAX)) ? WORD_MAX : q[15:0];
    endfunction : loop_value

    // derived words
    logic signed [15:0] run_signed;
    logic signed [15:0] set_signed;
    logic [15:0]        run_mag;
    logic [15:0]        set_mag;
    logic [19:0]        cur_scaled;
    logic [15:0]        cur_word;
    logic [15:0]        in_word;
    logic [15:0]        out_word;
    logic [31:0]        lin_quot;
    logic [15:0]        lin_word;
    logic [15:0]        remain_word;

    assign run_signed = scale_freq(drive_in.run_freq,
                                   frequency_resolution_select); // R4
    assign set_signed = scale_freq(drive_in.set_freq,
                                   frequency_resolution_select); // R4
    assign run_mag = run_signed[15] ? 16'(-run_signed)
                                    : run_signed; // R5
    assign set_mag = set_signed[15] ? 16'(-set_signed)
                                    : set_signed; // R5

    // large units lose a decimal; the word saturates at 0xffff instead of wrapping
    assign cur_scaled = large_unit ? drive_in.out_cur / 20'd10
                                   : drive_in.out_cur; // R6
    assign cur_word = (cur_scaled > 20'(WORD_MAX)) ? WORD_MAX
                                                   : cur_scaled[15:0]; // R6

    assign in_word = {1'b0, drive_in.virtual_input,
                      5'h00, drive_in.switch_input}; // R2

    logic [15:0] out_bits;
    assign out_bits = (16'(drive_in.relay_out) << OUT_RELAY)
                    | (16'(drive_in.switch_output) << OUT_DOUT)
                    | (16'(drive_in.virtual_output) << OUT_VIRT_LSB); // R3
    assign out_word = out_bits & OUT_LVL_LIMIT; // R3

    // zero setting would divide by zero; report stopped instead
    assign lin_quot = (pulses_per_metre_setting == 16'h0000) ? 32'h0
                    : drive_in.pulses_per_min
                      / 32'(pulses_per_metre_setting); // R11
    assign lin_word = (lin_quot > 32'(WORD_MAX)) ? WORD_MAX
                                                 : lin_quot[15:0]; // R11

    assign remain_word = timed_run_enable
                       ? clamp_u(drive_in.remain_time, REMAIN_MAX)
                       : RESET_WORD; // R12

    // snapshot registers: each word except host_set_reg is refreshed every cycle
    logic [15:0] run_freq_reg;
    logic [15:0] set_freq_reg;
    logic [15:0] bus_volt_reg;
    logic [15:0] out_volt_reg;
    logic [15:0] out_cur_reg;
    logic [15:0] out_pow_reg;
    logic [15:0] out_trq_reg;
    logic [15:0] in_lvl_reg;
    logic [15:0] out_lvl_reg;
    logic [15:0] load_spd_reg;
    logic [15:0] loop_set_reg;
    logic [15:0] loop_fb_reg;
    logic [15:0] act_freq_reg;
    logic [15:0] remain_reg;
    logic [15:0] an1_reg;
    logic [15:0] an2_reg;
    logic [15:0] lin_spd_reg;
    logic [15:0] host_set_reg;
    logic [15:0] enc_freq_reg;
    logic [15:0] main_freq_reg;
    logic [15:0] aux_freq_reg;
    logic [15:0] tgt_trq_reg;
    logic [15:0] resolver_reg;
    logic [15:0] pf_angle_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_freq_reg  <= RESET_WORD;
            set_freq_reg  <= RESET_WORD;
            bus_volt_reg  <= RESET_WORD;
            out_volt_reg  <= RESET_WORD;
            out_cur_reg   <= RESET_WORD;
            out_pow_reg   <= RESET_WORD;
            out_trq_reg   <= RESET_WORD;
            in_lvl_reg    <= RESET_WORD;
            out_lvl_reg   <= RESET_WORD;
            load_spd_reg  <= RESET_WORD;
            loop_set_reg  <= RESET_WORD;
            loop_fb_reg   <= RESET_WORD;
            act_freq_reg  <= RESET_WORD;
            remain_reg    <= RESET_WORD;
            an1_reg       <= RESET_WORD;
            an2_reg       <= RESET_WORD;
            lin_spd_reg   <= RESET_WORD;
            enc_freq_reg  <= RESET_WORD;
            main_freq_reg <= RESET_WORD;
            aux_freq_reg  <= RESET_WORD;
            tgt_trq_reg   <= RESET_WORD;
            resolver_reg  <= RESET_WORD;
            pf_angle_reg  <= RESET_WORD;
        end else begin
            run_freq_reg  <= run_mag; // R5
            set_freq_reg  <= set_mag; // R5
            bus_volt_reg  <= drive_in.bus_volt;
            out_volt_reg  <= drive_in.out_volt;
            out_cur_reg   <= cur_word; // R6
            out_pow_reg   <= drive_in.out_power;
            out_trq_reg   <= clamp_torque(drive_in.out_torque); // R9
            in_lvl_reg    <= in_word; // R2
            out_lvl_reg   <= out_word; // R3
            load_spd_reg  <= drive_in.load_speed;
            loop_set_reg  <= loop_value(drive_in.loop_set_pct,
                                        loop_scale_setting); // R14
            loop_fb_reg   <= loop_value(drive_in.loop_fb_pct,
                                        loop_scale_setting); // R14
            act_freq_reg  <= scale_freq(drive_in.act_freq,
                                        frequency_resolution_select); // R4
            remain_reg    <= remain_word; // R12
            an1_reg       <= clamp_u(drive_in.an1_raw, ANALOG_MAX); // R13
            an2_reg       <= clamp_u(drive_in.an2_raw, ANALOG_MAX); // R13
            lin_spd_reg   <= lin_word; // R11
            enc_freq_reg  <= scale_freq(drive_in.enc_freq,
                                        frequency_resolution_select); // R4
            main_freq_reg <= scale_freq(drive_in.main_freq,
                                        frequency_resolution_select); // R4
            aux_freq_reg  <= scale_freq(drive_in.aux_freq,
                                        frequency_resolution_select); // R4
            tgt_trq_reg   <= clamp_torque(drive_in.torque_limit); // R10
            resolver_reg  <= clamp_u(drive_in.resolver, RESOLVER_MAX); // R8
            pf_angle_reg  <= drive_in.pf_angle;
        end
    end

    // host decode
    logic       in_span;
    logic       host_set_hit;
    logic [6:0] word_ix;

    assign in_span = (host_req.addr >= MON_BASE)
                  && (host_req.addr <= MON_LAST); // R1
    assign word_ix = 7'(host_req.addr - MON_BASE);
    assign host_set_hit = host_req.wr
                       && (host_req.addr == HOST_SET_ADDR); // R7

    // the only write that lands; monitor span writes fall through
    always_ff @(posedge clock) begin
        if (sys_rst)
            host_set_reg <= RESET_WORD;
        else if (host_set_hit)
            host_set_reg <= host_req.wdata; // R7
    end

    // read selection; reserved words inside the span read zero
    logic [15:0] read_word;
    logic        read_mapped;

    always_comb begin
        read_mapped = 1'b1;
        unique case (word_ix)
            IX_RUN_FREQ:  read_word = run_freq_reg;
            IX_SET_FREQ:  read_word = set_freq_reg;
            IX_BUS_VOLT:  read_word = bus_volt_reg;
            IX_OUT_VOLT:  read_word = out_volt_reg;
            IX_OUT_CUR:   read_word = out_cur_reg;
            IX_OUT_POW:   read_word = out_pow_reg;
            IX_OUT_TRQ:   read_word = out_trq_reg;
            IX_IN_LVL:    read_word = in_lvl_reg;
            IX_OUT_LVL:   read_word = out_lvl_reg;
            IX_LOAD_SPD:  read_word = load_spd_reg;
            IX_LOOP_SET:  read_word = loop_set_reg;
            IX_LOOP_FB:   read_word = loop_fb_reg;
            IX_ACT_FREQ:  read_word = act_freq_reg;
            IX_REMAIN:    read_word = remain_reg;
            IX_AN1_RAW:   read_word = an1_reg;
            IX_AN2_RAW:   read_word = an2_reg;
            IX_LIN_SPD:   read_word = lin_spd_reg;
            IX_HOST_SET:  read_word = host_set_reg; // R7
            IX_ENC_FREQ:  read_word = enc_freq_reg;
            IX_MAIN_FREQ: read_word = main_freq_reg;
            IX_AUX_FREQ:  read_word = aux_freq_reg;
            IX_TGT_TRQ:   read_word = tgt_trq_reg;
            IX_RESOLVER:  read_word = resolver_reg;
            IX_PF_ANGLE:  read_word = pf_angle_reg;
            default: begin
                read_word   = RESET_WORD;
                read_mapped = 1'b0;
            end
        endcase
    end

    // answer one cycle after the request; reads change no state
    logic        ack_next;
    logic        err_next;
    logic [15:0] rdata_next;
    logic        ack_reg;
    logic        err_reg;
    logic [15:0] rdata_reg;

    assign ack_next   = host_req.rd || host_req.wr;
    assign err_next   = (host_req.rd && !in_span)
                     || (host_req.wr && !host_set_hit); // R15
    assign rdata_next = (host_req.rd && in_span && read_mapped)
                      ? read_word : RESET_WORD; // R1

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= RESET_WORD;
        end else begin
            ack_reg   <= ack_next;
            err_reg   <= err_next;
            rdata_reg <= rdata_next; // R15
        end
    end

    assign host_rsp.ack   = ack_reg;
    assign host_rsp.err   = err_reg;
    assign host_rsp.rdata = rdata_reg;
endmodule : drive_monitor_status_bank

// ---- sim/monitor_bank_checker.sv ----
`timescale 1ns/1ps
module monitor_bank_checker
    import monitor_pkg::*;
(
    // clock and reset
    input wire logic                       clock,
    input wire logic                       sys_rst,
    // host side and drive samples
    input wire monitor_pkg::host_req_t     host_req,
    input wire monitor_pkg::host_rsp_t     host_rsp,
    input wire monitor_pkg::drive_sample_t drive_in
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    wire        rd_only = host_req.rd && !host_req.wr;
    wire        wr_only = host_req.wr && !host_req.rd;
    wire        in_span = host_req.addr >= MON_BASE
                       && host_req.addr <= MON_LAST;
    wire [15:0] ra      = host_req.addr;
    wire [15:0] rq      = host_rsp.rdata;

    a_ack_follows: assert property (
        (host_req.rd || host_req.wr) |=> host_rsp.ack)
        else $error("no ack after request");
    a_ack_only_req: assert property (
        !(host_req.rd || host_req.wr) |=> !host_rsp.ack)
        else $error("ack without request");
    a_span_read_ok: assert property (
        rd_only && in_span |=> !host_rsp.err)
        else $error("read in span flagged");
    a_out_span_err: assert property (
        rd_only && !in_span |=> host_rsp.err && rq == 16'h0000)
        else $error("read outside span not refused");
    a_write_ignored: assert property (
        wr_only && ra != HOST_SET_ADDR |=> host_rsp.err && rq == 16'h0000)
        else $error("monitor write not ignored");
    a_set_readback: assert property (
        (wr_only && ra == HOST_SET_ADDR) ##1 !host_req.wr
        ##1 (rd_only && ra == 16'h701b)
        |=> rq == $past(host_req.wdata, 3))
        else $error("host setting not read back");
    a_in_word: assert property (
        rd_only && ra == 16'h7007 && !$past(sys_rst) |=>
        rq == {1'b0, $past(drive_in.virtual_input, 2), 5'h00,
               $past(drive_in.switch_input, 2)})
        else $error("input word layout wrong");
    a_out_word: assert property (
        rd_only && ra == 16'h7008 && !$past(sys_rst) |=>
        rq == {6'h00, $past(drive_in.virtual_output, 2), 1'b0,
               $past(drive_in.switch_output, 2), 1'b0,
               $past(drive_in.relay_out, 2), 1'b0})
        else $error("output word layout wrong");
    a_resolver_cap: assert property (
        rd_only && ra == 16'h7023 |=> rq <= RESOLVER_MAX)
        else $error("resolver above range");
    a_torque_band: assert property (
        rd_only && (ra == 16'h7006 || ra == 16'h7022) |=>
        $signed(rq) <= TORQUE_LIMIT && $signed(rq) >= -TORQUE_LIMIT)
        else $error("torque outside band");

    c_read: cover property (rd_only && in_span ##1 host_rsp.ack);
    c_set_write: cover property (wr_only && ra == HOST_SET_ADDR);
    c_refused: cover property (host_rsp.ack && host_rsp.err);
endmodule : monitor_bank_checker

bind drive_monitor_status_bank monitor_bank_checker u_chk (
    .clock(clock), .sys_rst(sys_rst), .host_req(host_req),
    .host_rsp(host_rsp), .drive_in(drive_in));

// ---- sim/host_link_model.sv ----
`timescale 1ns/1ps
module host_link_model
    import monitor_pkg::*;
(
    // clock
    input  wire logic                   clock,
    // request out, answer in
    output monitor_pkg::host_req_t      host_req,
    input  wire monitor_pkg::host_rsp_t host_rsp
);
    initial begin
        host_req = '0;
    end

    // one-cycle request, then wait a bounded time for the answer
    task automatic xfer(input logic wr, input logic [15:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata,
                        output logic err, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 16'h0000;
        err = 1'b0;
        @(negedge clock);
        host_req.rd = !wr;
        host_req.wr = wr;
        host_req.addr = addr;
        host_req.wdata = wdata;
        @(negedge clock);
        host_req.rd = 1'b0;
        host_req.wr = 1'b0;
        // released lines must not keep showing the old value
        host_req.addr = ~addr;
        host_req.wdata = ~wdata;
        for (n = 0; n < 4 && !ok; n++) begin
            if (host_rsp.ack === 1'b1) begin
                ok = 1'b1;
                rdata = host_rsp.rdata;
                err = host_rsp.err;
            end else begin
                @(negedge clock);
            end
        end
    endtask : xfer
endmodule : host_link_model

// ---- sim/drive_monitor_status_bank_tb.sv ----
`timescale 1ns/1ps
module drive_monitor_status_bank_tb;
    import monitor_pkg::*;
    logic          clock;
    logic          sys_rst;
    logic          large_unit;
    logic          timed_run_enable;
    logic [1:0]    frequency_resolution_select;
    logic [15:0]   pulses_per_metre_setting;
    logic [15:0]   loop_scale_setting;
    host_req_t     host_req;
    host_rsp_t     host_rsp;
    drive_sample_t drive_in;
    logic [15:0]   rdata;
    logic          err;
    logic          ok;
    int            error_cnt;
    int            n_checks;

    drive_monitor_status_bank dut (
        .clock(clock), .sys_rst(sys_rst), .host_req(host_req),
        .host_rsp(host_rsp), .drive_in(drive_in),
        .frequency_resolution_select(frequency_resolution_select),
        .pulses_per_metre_setting(pulses_per_metre_setting),
        .loop_scale_setting(loop_scale_setting),
        .large_unit(large_unit), .timed_run_enable(timed_run_enable));
    host_link_model host (
        .clock(clock), .host_req(host_req), .host_rsp(host_rsp));

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic access(input logic wr, input logic [15:0] addr,
                          input logic [15:0] wdata);
        host.xfer(wr, addr, wdata, rdata, err, ok);
        if (!ok) begin
            chk("ack", 16'h0000, 16'h0001);
            summarize();
        end
    endtask : access

    task automatic rd_chk(input string name, input logic [15:0] addr,
                          input logic [15:0] exp);
        access(1'b0, addr, 16'h0000);
        chk(name, rdata, exp);
        chk("rd_err", {15'h0000, err}, 16'h0000);
    endtask : rd_chk

    // ph 0: two decimals, small unit; ph 1: one decimal, large unit
    task automatic sweep(input bit ph);
        rd_chk("run_freq", 16'h7000, ph ? 16'h04d2 : 16'h3039);
        rd_chk("set_freq", 16'h7001, ph ? 16'h0066 : 16'h0400);
        rd_chk("current", 16'h7004, ph ? 16'h1b58 : 16'hffff);
        rd_chk("torque", 16'h7006, 16'h07d0);
        rd_chk("in_lvl", 16'h7007, 16'h2815);
        rd_chk("out_lvl", 16'h7008, 16'h022a);
        rd_chk("loop_set", 16'h700f, ph ? 16'h7530 : 16'h01f4);
        rd_chk("loop_fb", 16'h7010, ph ? 16'hffff : 16'h07d0);
        rd_chk("act_freq", 16'h7013, ph ? 16'hff85 : 16'hfb2e);
        rd_chk("remain", 16'h7014, ph ? 16'h0000 : 16'hfde8);
        rd_chk("an1_raw", 16'h7015, 16'h0421);
        rd_chk("an2_raw", 16'h7016, 16'h01f4);
        rd_chk("lin_spd", 16'h7018, ph ? 16'h0000 : 16'h2710);
        rd_chk("enc_freq", 16'h701c, ph ? 16'h0fa0 : 16'h7530);
        rd_chk("main_freq", 16'h701d, ph ? 16'h0bb8 : 16'h7530);
        rd_chk("aux_freq", 16'h701e, ph ? 16'hf060 : 16'h8ad0);
        rd_chk("tgt_trq", 16'h7022, 16'hf830);
        rd_chk("resolver", 16'h7023, 16'h0fff);
    endtask : sweep

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        error_cnt = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        drive_in = '0;
        frequency_resolution_select = RES_HUNDREDTHS;
        large_unit = 1'b0;
        timed_run_enable = 1'b1;
        loop_scale_setting = 16'h03e8;
        pulses_per_metre_setting = 16'h0064;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        chk("rst_ack", {15'h0000, host_rsp.ack}, 16'h0000);
        // values chosen to sit past every clamp at least once, except the linear speed saturation
        drive_in.run_freq = 20'hfcfc7;
        drive_in.set_freq = 20'h00400;
        drive_in.act_freq = 20'hffb2e;
        drive_in.enc_freq = 20'h09c40;
        drive_in.main_freq = 20'h07531;
        drive_in.aux_freq = 20'hf63c0;
        drive_in.out_cur = 20'h11170;
        drive_in.out_torque = 16'h0bb8;
        drive_in.torque_limit = 16'hf63c;
        drive_in.switch_input = 5'h15;
        drive_in.virtual_input = 5'h0a;
        drive_in.relay_out = 1'b1;
        drive_in.switch_output = 1'b1;
        drive_in.virtual_output = 5'h11;
        drive_in.loop_set_pct = 16'h1388;
        drive_in.loop_fb_pct = 16'h4e20;
        drive_in.remain_time = 16'hffff;
        drive_in.an1_raw = 16'h07d0;
        drive_in.an2_raw = 16'h01f4;
        drive_in.pulses_per_min = 32'h000f4240;
        drive_in.resolver = 16'h2000;
        drive_in.bus_volt = 16'h0bb8;
        drive_in.out_volt = 16'h0474;
        drive_in.out_power = 16'h7fff;
        drive_in.load_speed = 16'hffff;
        drive_in.pf_angle = 16'h0123;
        sweep(1'b0);
        frequency_resolution_select = RES_TENTHS;
        large_unit = 1'b1;
        timed_run_enable = 1'b0;
        loop_scale_setting = 16'hea60;
        pulses_per_metre_setting = 16'h0000;
        sweep(1'b1);
        // plain pass-through words, never touched by scaling
        rd_chk("bus_volt", 16'h7002, 16'h0bb8);
        rd_chk("out_volt", 16'h7003, 16'h0474);
        rd_chk("out_pow", 16'h7005, 16'h7fff);
        rd_chk("load_spd", 16'h700e, 16'hffff);
        rd_chk("pf_angle", 16'h7024, 16'h0123);
        access(1'b1, HOST_SET_ADDR, 16'h8123);
        chk("set_err", {15'h0000, err}, 16'h0000);
        rd_chk("host_set", 16'h701b, 16'h8123);
        access(1'b1, 16'h7006, 16'h1111);
        chk("span_wr_err", {15'h0000, err}, 16'h0001);
        rd_chk("torque_kept", 16'h7006, 16'h07d0);
        rd_chk("reserved", 16'h7009, 16'h0000);
        access(1'b0, 16'h7045, 16'h0000);
        chk("past_end", {15'h0000, err}, 16'h0001);
        access(1'b0, 16'h7044, 16'h0000);
        chk("last_word", {15'h0000, err}, 16'h0000);
        summarize();
    end
endmodule : drive_monitor_status_bank_tb
